// ==== hw/mcrd_top.sv ====
// Rate divider for the clock enable of the external memory interface
//
// Behaviour
// (R1) Select bit 1, the reset value, runs the interface at the full system rate.
// (R2) Select bit 0 runs the interface at half the system clock rate.
// (R3) The chosen rate serves asynchronous and synchronous DRAM timing alike.
// (R4) Software should pick half rate only when synchronous DRAM timing needs it.
// (R5) Select sits in bit 0; bits 15-1 read zero; divide done internally.
// (R6) Rate changes land on a cycle boundary, never giving a short pulse.
`timescale 1ns/1ns
`include "mcrd_defines.svh"

module mcrd_top (
  input  wire logic                    sys_clk,         // 100 MHz system clock
  input  wire logic                    rst,             // Sync reset, active high
  input  wire logic                    psel,            // APB select
  input  wire logic                    penable,         // APB access phase
  input  wire mcrd_pkg::mcrd_apb_req_t apb_req,         // APB address, data, strobes
  output logic [31:0]                  prdata,          // APB read data
  output logic                         pready,          // APB ready
  output logic                         pslverr,         // APB error, unmapped
  output logic                         memif_clk_en,    // Interface clock enable
  output logic                         memif_half_rate  // Interface at half rate
);
  import mcrd_pkg::*;

  // ==========================================================
  // Register map checks
  // ==========================================================
  if (`MCRD_CTRL_ADDR != 4 * `MCRD_CTRL_IDX) begin : g_addr_chk
    $error("Control byte address is not four times its index");
  end
  if (`MCRD_SEL_BIT > 15) begin : g_sel_chk
    $error("Select bit outside the 16-bit control register");
  end

  // ==========================================================
  // Decode
  // ==========================================================
  function automatic logic ctrl_hit(input logic [15:0] addr);
    return addr == `MCRD_CTRL_ADDR;
  endfunction

  logic       setup_ph;
  logic       access_ph;
  logic       hit;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit       = ctrl_hit(apb_req.paddr);

  // ==========================================================
  // Control register
  // ==========================================================
  logic        ctrl_sel;
  logic        next_ctrl_sel;
  logic [31:0] next_prdata;
  localparam logic [15:0] ctrl_reset_val = `MCRD_CTRL_RESET;

  always_comb begin
    next_ctrl_sel = ctrl_sel;
    next_prdata   = prdata;
    // (R5) Bit 0 write
    if (access_ph && hit && apb_req.pwrite && apb_req.pstrb[`MCRD_STRB_LANE]) begin
      next_ctrl_sel = apb_req.pwdata[`MCRD_SEL_BIT];
    end
    // (R5) Reserved read zero
    if (setup_ph) begin
      next_prdata = 32'h0000_0000;
      if (hit && !apb_req.pwrite) begin
        next_prdata[`MCRD_SEL_BIT] = ctrl_sel;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_sel <= ctrl_reset_val[`MCRD_SEL_BIT];
      prdata   <= 32'h0000_0000;
    end else begin
      ctrl_sel <= next_ctrl_sel;
      prdata   <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit;

  // ==========================================================
  // Rate divider
  // ==========================================================
  mcrd_rate_t rate_st;
  mcrd_rate_t next_rate_st;
  logic       next_clk_en;

  always_comb begin
    next_rate_st = rate_st;
    case (rate_st)
      // (R1) Full rate hold
      MCRD_FULL: begin
        next_rate_st = ctrl_sel ? MCRD_FULL : MCRD_HALF_OFF;
      end
      // (R2) Half rate pulse
      MCRD_HALF_ON: begin
        next_rate_st = MCRD_HALF_OFF;
      end
      // (R6) Switch at boundary
      MCRD_HALF_OFF: begin
        next_rate_st = ctrl_sel ? MCRD_FULL : MCRD_HALF_ON;
      end
      default: begin
        next_rate_st = MCRD_FULL;
      end
    endcase
    // (R3) One enable, all modes
    next_clk_en = (next_rate_st != MCRD_HALF_OFF);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rate_st      <= MCRD_FULL;
      memif_clk_en <= 1'b1;
    end else begin
      rate_st      <= next_rate_st;
      memif_clk_en <= next_clk_en;
    end
  end

  assign memif_half_rate = (rate_st != MCRD_FULL);

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_full_rate;
    @(posedge sys_clk) disable iff (rst)
      ctrl_sel [*3] |-> memif_clk_en && !memif_half_rate;
  endproperty
  a_full_rate: assert property (p_full_rate) // (R1)
    else $error("Full rate selected but enable not every cycle");

  property p_half_gap;
    @(posedge sys_clk) disable iff (rst)
      (!ctrl_sel && memif_clk_en) |=> !memif_clk_en;
  endproperty
  a_half_gap: assert property (p_half_gap) // (R2)
    else $error("Half rate selected but enable pulses back to back");

  property p_half_pulse;
    @(posedge sys_clk) disable iff (rst)
      (!ctrl_sel ##1 (!ctrl_sel && !memif_clk_en)) |=> memif_clk_en;
  endproperty
  a_half_pulse: assert property (p_half_pulse) // (R2)
    else $error("Half rate enable missing its pulse");

  property p_no_bypass;
    @(posedge sys_clk) disable iff (rst)
      !ctrl_sel [*2] |-> memif_half_rate;
  endproperty
  a_no_bypass: assert property (p_no_bypass) // (R3)
    else $error("Half rate select bypassed");

  property p_write_sel;
    @(posedge sys_clk) disable iff (rst)
      (access_ph && hit && apb_req.pwrite && apb_req.pstrb[0])
        |=> ctrl_sel == $past(apb_req.pwdata[0]);
  endproperty
  a_write_sel: assert property (p_write_sel) // (R5)
    else $error("Select bit not written");

  property p_read_sel;
    @(posedge sys_clk) disable iff (rst)
      (setup_ph && hit && !apb_req.pwrite)
        |=> prdata[31:1] == 31'h0000_0000 && prdata[0] == $past(ctrl_sel);
  endproperty
  a_read_sel: assert property (p_read_sel) // (R5)
    else $error("Read data wrong or reserved bits set");

  property p_unmapped;
    @(posedge sys_clk) disable iff (rst)
      (access_ph && !hit) |-> pslverr ##1 $stable(ctrl_sel);
  endproperty
  a_unmapped: assert property (p_unmapped) // (R5)
    else $error("Unmapped access not refused");

  property p_no_double_gap;
    @(posedge sys_clk) disable iff (rst)
      !memif_clk_en |=> memif_clk_en;
  endproperty
  a_no_double_gap: assert property (p_no_double_gap) // (R6)
    else $error("Enable gap longer than one cycle");

  property p_enter_half;
    @(posedge sys_clk) disable iff (rst)
      $rose(memif_half_rate) |-> !memif_clk_en && $past(memif_clk_en);
  endproperty
  a_enter_half: assert property (p_enter_half) // (R6)
    else $error("Half rate entered off a boundary");

  property p_leave_half;
    @(posedge sys_clk) disable iff (rst)
      $fell(memif_half_rate) |-> $past(!memif_clk_en) && memif_clk_en;
  endproperty
  a_leave_half: assert property (p_leave_half) // (R6)
    else $error("Full rate resumed off a boundary");

  property p_ready_high;
    @(posedge sys_clk) disable iff (rst)
      psel |-> pready;
  endproperty
  a_ready_high: assert property (p_ready_high) // (R5)
    else $error("Ready low during a transfer");

  property p_mapped_ok;
    @(posedge sys_clk) disable iff (rst)
      (access_ph && hit) |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) // (R5)
    else $error("Error raised on the control register");

  property p_idle_no_err;
    @(posedge sys_clk) disable iff (rst)
      !access_ph |-> !pslverr;
  endproperty
  a_idle_no_err: assert property (p_idle_no_err) // (R5)
    else $error("Error raised outside an access cycle");

  property p_prdata_hold;
    @(posedge sys_clk) disable iff (rst)
      !setup_ph |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) // (R5)
    else $error("Read data changed outside a setup cycle");

  property p_unmapped_data;
    @(posedge sys_clk) disable iff (rst)
      (setup_ph && !hit) |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped_data: assert property (p_unmapped_data) // (R5)
    else $error("Unmapped read returned nonzero data");

  property p_sel_hold;
    @(posedge sys_clk) disable iff (rst)
      !(access_ph && hit && apb_req.pwrite && apb_req.pstrb[0]) |=> $stable(ctrl_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) // (R5)
    else $error("Select bit changed without a write to it");

  property p_reset_full;
    @(posedge sys_clk)
      rst |=> memif_clk_en && !memif_half_rate && ctrl_sel && prdata == 32'h0000_0000;
  endproperty
  a_reset_full: assert property (p_reset_full) // (R1)
    else $error("Reset did not restore full rate");

  property p_half_alternate;
    @(posedge sys_clk) disable iff (rst)
      (memif_half_rate && memif_clk_en) |=> !memif_clk_en;
  endproperty
  a_half_alternate: assert property (p_half_alternate) // (R6)
    else $error("Half rate pulse followed by another pulse");

  property p_gap_only_half;
    @(posedge sys_clk) disable iff (rst)
      !memif_clk_en |-> memif_half_rate;
  endproperty
  a_gap_only_half: assert property (p_gap_only_half) // (R3)
    else $error("Enable gap while at full rate");

  property p_half_after_fall;
    @(posedge sys_clk) disable iff (rst)
      $fell(ctrl_sel) |=> memif_half_rate;
  endproperty
  a_half_after_fall: assert property (p_half_after_fall) // (R2)
    else $error("Half rate not entered after select cleared");

  property p_half_hold;
    @(posedge sys_clk) disable iff (rst)
      (memif_half_rate && !ctrl_sel) |=> memif_half_rate;
  endproperty
  a_half_hold: assert property (p_half_hold) // (R3)
    else $error("Half rate left while select still clear");

  property p_full_return;
    @(posedge sys_clk) disable iff (rst)
      ($rose(ctrl_sel) ##1 ctrl_sel) |-> ##[0:1] !memif_half_rate;
  endproperty
  a_full_return: assert property (p_full_return) // (R6)
    else $error("Full rate not resumed within two cycles");

  property p_full_steady;
    @(posedge sys_clk) disable iff (rst)
      (!memif_half_rate && ctrl_sel) |=> !memif_half_rate;
  endproperty
  a_full_steady: assert property (p_full_steady) // (R1)
    else $error("Full rate left while select set");

  c_go_half: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(memif_half_rate));
  c_go_full: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(memif_half_rate));
  c_write: cover property (@(posedge sys_clk) disable iff (rst)
    access_ph && hit && apb_req.pwrite);
  c_read: cover property (@(posedge sys_clk) disable iff (rst)
    access_ph && hit && !apb_req.pwrite);
  c_lane_off: cover property (@(posedge sys_clk) disable iff (rst)
    access_ph && hit && apb_req.pwrite && !apb_req.pstrb[0]);

endmodule

// ==== pkg/mcrd_defines.svh ====
// Register map, field layout and reset values of the interface clock divider
`ifndef MCRD_DEFINES_SVH
`define MCRD_DEFINES_SVH

// Register index; the APB byte address is four times it
`define MCRD_CTRL_IDX   16'h1c26
`define MCRD_CTRL_ADDR  16'h7098
`define MCRD_CTRL_RESET 16'h0001
`define MCRD_SEL_BIT    0
`define MCRD_STRB_LANE  0

`endif

// ==== pkg/mcrd_pkg.sv ====
// Types shared by the interface clock divider and its bench
package mcrd_pkg;

  // APB request fields that travel together
  typedef struct packed {
    logic [15:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } mcrd_apb_req_t;

  // Divider phase
  typedef enum logic [1:0] {
    MCRD_FULL     = 2'b00,
    MCRD_HALF_ON  = 2'b01,
    MCRD_HALF_OFF = 2'b10
  } mcrd_rate_t;

endpackage

// ==== tb/mcrd_top_tb_top.sv ====
// Self-checking bench for the interface clock rate divider
`timescale 1ns/1ns
`include "mcrd_defines.svh"

module mcrd_top_tb_top;
  import mcrd_pkg::*;
  logic          sys_clk;
  logic          rst;
  logic          psel;
  logic          penable;
  mcrd_apb_req_t apb_req;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          memif_clk_en;
  logic          memif_half_rate;
  logic [31:0]   rd;
  logic          er;
  int            err_count;
  int            samples_checked;

  mcrd_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memif_clk_en(memif_clk_en),
    .memif_half_rate(memif_half_rate));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================
  // One APB transfer, ready awaited with no bound; access cycle count checked to be 1
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    apb_req <= '{paddr: a, pwrite: w, pwdata: d, pstrb: s};
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1);
    chk("access cycles", 32'h1, n);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // ==========================================
  // Counts enable highs over n cycles and any two lows in a row
  task automatic watch(input int n, input int hi_exp, input logic hr_exp);
    int   hi;
    int   dbl;
    logic prev;
    hi = 0;
    dbl = 0;
    prev = 1'h1;
    repeat (n) begin
      @(negedge sys_clk);
      if (memif_clk_en === 1'h1) hi++;
      if (memif_clk_en !== 1'h1 && prev !== 1'h1) dbl++;
      prev = memif_clk_en;
      chk("memif_half_rate", {31'h0, hr_exp}, {31'h0, memif_half_rate});
    end
    chk("enable highs", hi_exp, hi);
    chk("double low", 32'h0, dbl);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    apb_req = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    apb(`MCRD_CTRL_ADDR, 1'h0, 32'h0, 4'h0);
    chk("ctrl after reset", {16'h0, `MCRD_CTRL_RESET}, rd);
    chk("pslverr mapped", 32'h0, {31'h0, er});
    watch(8, 8, 1'h0);
    $display("test reset done");
    apb(`MCRD_CTRL_ADDR, 1'h1, 32'h0, 4'hf);
    @(negedge sys_clk);
    chk("enable at switch", 32'h1, {31'h0, memif_clk_en});
    chk("half at switch", 32'h0, {31'h0, memif_half_rate});
    watch(8, 4, 1'h1);
    apb(`MCRD_CTRL_ADDR, 1'h0, 32'h0, 4'h0);
    chk("ctrl half", 32'h0, rd);
    $display("test half rate done");
    apb(`MCRD_CTRL_ADDR, 1'h1, 32'hffffffff, 4'he);
    apb(`MCRD_CTRL_ADDR, 1'h0, 32'h0, 4'h0);
    chk("ctrl lane off", 32'h0, rd);
    apb(`MCRD_CTRL_ADDR, 1'h1, 32'hffffffff, 4'h1);
    apb(`MCRD_CTRL_ADDR, 1'h0, 32'h0, 4'h0);
    chk("ctrl reserved", 32'h1, rd);
    watch(8, 8, 1'h0);
    $display("test full rate done");
    apb(`MCRD_CTRL_IDX, 1'h0, 32'h0, 4'h0);
    chk("pslverr unmapped", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(16'h7000, 1'h1, 32'h0, 4'hf);
    apb(`MCRD_CTRL_ADDR, 1'h0, 32'h0, 4'h0);
    chk("ctrl kept", 32'h1, rd);
    $display("test unmapped done");
    apb(`MCRD_CTRL_ADDR, 1'h1, 32'h0, 4'h1);
    @(negedge sys_clk);
    watch(4, 2, 1'h1);
    @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    apb(`MCRD_CTRL_ADDR, 1'h0, 32'h0, 4'h0);
    chk("ctrl after second reset", {16'h0, `MCRD_CTRL_RESET}, rd);
    watch(8, 8, 1'h0);
    $display("test mid-run reset done");
    finish_test();
  end

  // Watchdog, far beyond the roughly 82 cycles the tests need
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
endmodule
